// ### design/vectored_interrupt_prioritizer.sv
// central request collector: pending, mask, steering, vectors, avalon slave
`timescale 1ns/1ps
module vectored_interrupt_prioritizer
   import vip_pkg::*;
(
   input  wire logic              clock,
   input  wire logic              rstn,
   // avalon-mm slave
   input  wire logic [ADDR_W-1:0] address,
   input  wire logic              read,
   input  wire logic              write,
   input  wire logic [DATA_W-1:0] writedata,
   input  wire logic [3:0]        byteenable,
   output logic      [DATA_W-1:0] readdata,
   output logic                   waitrequest,
   // request sources
   input  wire logic              brownout_request,
   input  wire logic              external_pin_request,
   input  wire logic              watchdog_expiry_request,
   input  wire logic              watchdog_half_time_request,
   input  wire logic              serial_error_request,
   input  wire logic              serial0_receive_request,
   input  wire logic              serial0_transmit_request,
   input  wire logic              serial1_receive_request,
   input  wire logic              serial1_transmit_request,
   input  wire logic              pmbus_request,
   input  wire logic              digital_compare_request,
   input  wire logic              front_end_zero_request,
   input  wire logic              front_end_one_request,
   input  wire logic              front_end_two_request,
   input  wire logic              small_timer_zero_request,
   input  wire logic              small_timer_one_request,
   input  wire logic              small_timer_two_request,
   input  wire logic              small_timer_three_request,
   input  wire logic              wide_timer_overflow_request,
   input  wire logic              wide_timer_capture1_request,
   input  wire logic              wide_timer_compare1_request,
   input  wire logic              wide_timer_capture0_request,
   input  wire logic              wide_timer_compare0_request,
   input  wire logic              power_current_mode_request,
   input  wire logic              conversion_done_request,
   input  wire logic              fault_mux_request,
   input  wire logic              pulse_generator_zero_request,
   input  wire logic              pulse_generator_one_request,
   input  wire logic              pulse_generator_two_request,
   input  wire logic              pulse_generator_three_request,
   input  wire logic              fault_pin_request,
   // core side
   output logic                   fast_interrupt_level,
   output logic                   normal_interrupt_level,
   output logic                   irq
);

   // ****************************************
   // helper functions
   // ****************************************

   // highest set bit wins; returns {valid, index}
   function automatic logic [IDX_W:0] top_channel(input logic [NUM_CHANNELS-1:0] v);
      logic [IDX_W:0] r;
      r = '0;
      for (int i = 0; i < NUM_CHANNELS; i++) begin
         if (v[i]) begin
            r = {1'b1, IDX_W'(i)}; // later, higher channel overrides
         end
      end
      return r;
   endfunction

   // byte enables widened to a bit mask
   function automatic logic [DATA_W-1:0] lane_mask(input logic [3:0] be);
      logic [DATA_W-1:0] m;
      m = '0;
      for (int b = 0; b < 4; b++) begin
         m[b*8 +: 8] = {8{be[b]}};
      end
      return m;
   endfunction

   // ****************************************
   // state declarations
   // ****************************************
   logic [DATA_W-1:0]       pending_q;
   logic [DATA_W-1:0]       mask_q;
   logic [DATA_W-1:0]       steer_q;
   logic [IDX_W-1:0]        fast_idx_q;
   logic                    fast_vld_q;
   logic [IDX_W-1:0]        norm_idx_q;
   logic                    norm_vld_q;
   logic [DATA_W-1:0]       readdata_q;
   logic                    waitrequest_q;
   logic                    fast_level_q;
   logic                    norm_level_q;
   logic                    irq_q;
   logic [1:0]              pin_meta_q;
   logic [1:0]              pin_sync_q;
   logic [NUM_CHANNELS-1:0] req_vec;
   logic [DATA_W-1:0]       clr_vec;
   logic [DATA_W-1:0]       wmask;
   logic [DATA_W-1:0]       live;
   logic [DATA_W-1:0]       fast_src;
   logic [DATA_W-1:0]       norm_src;
   logic [IDX_W:0]          fast_top;
   logic [IDX_W:0]          norm_top;
   logic                    wr_go;
   logic                    soft_set;

   // ****************************************
   // pin synchronisers
   // ****************************************

   // both pins are asynchronous; meta stage feeds only the sync stage
   always_ff @(posedge clock) begin
      if (!rstn) begin
         pin_meta_q <= 2'b00;
         pin_sync_q <= 2'b00;
      end else begin
         pin_meta_q <= {fault_pin_request, external_pin_request};
         pin_sync_q <= pin_meta_q;
      end
   end

   // ****************************************
   // request routing
   // ****************************************
   assign req_vec[CH_BROWNOUT]     = brownout_request;
   assign req_vec[CH_EXT_PIN]      = pin_sync_q[0];
   assign req_vec[CH_WD_EXPIRY]    = watchdog_expiry_request;
   assign req_vec[CH_WD_HALF]      = watchdog_half_time_request;
   assign req_vec[CH_SER_ERR]      = serial_error_request;
   assign req_vec[CH_SER0_RX]      = serial0_receive_request;
   assign req_vec[CH_SER0_TX]      = serial0_transmit_request;
   assign req_vec[CH_SER1_RX]      = serial1_receive_request;
   assign req_vec[CH_SER1_TX]      = serial1_transmit_request;
   assign req_vec[CH_PMBUS]        = pmbus_request;
   assign req_vec[CH_DIG_CMP]      = digital_compare_request;
   assign req_vec[CH_FRONT_END0]   = front_end_zero_request;
   assign req_vec[CH_FRONT_END0+1] = front_end_one_request;
   assign req_vec[CH_FRONT_END0+2] = front_end_two_request;
   assign req_vec[CH_SMALL_TMR3]   = small_timer_three_request;
   assign req_vec[CH_SMALL_TMR3+1] = small_timer_two_request;
   assign req_vec[CH_SMALL_TMR3+2] = small_timer_one_request;
   assign req_vec[CH_SMALL_TMR3+3] = small_timer_zero_request;
   assign req_vec[CH_WIDE_OVF]     = wide_timer_overflow_request;
   assign req_vec[CH_WIDE_CAP1]    = wide_timer_capture1_request;
   assign req_vec[CH_WIDE_CMP1]    = wide_timer_compare1_request;
   assign req_vec[CH_WIDE_CAP0]    = wide_timer_capture0_request;
   assign req_vec[CH_WIDE_CMP0]    = wide_timer_compare0_request;
   assign req_vec[CH_PWR_MODE]     = power_current_mode_request;
   assign req_vec[CH_CONV_DONE]    = conversion_done_request;
   assign req_vec[CH_FAULT_MUX]    = fault_mux_request;
   assign req_vec[CH_PULSE_GEN3]   = pulse_generator_three_request;
   assign req_vec[CH_PULSE_GEN3+1] = pulse_generator_two_request;
   assign req_vec[CH_PULSE_GEN3+2] = pulse_generator_one_request;
   assign req_vec[CH_PULSE_GEN3+3] = pulse_generator_zero_request;
   assign req_vec[CH_FAULT_PIN]    = pin_sync_q[1];
   assign req_vec[CH_SOFTWARE]     = soft_set;

   // ****************************************
   // bus decode
   // ****************************************

   // a write lands only on the edge where waitrequest is seen low
   assign wr_go    = write && !waitrequest_q;
   assign wmask    = lane_mask(byteenable);
   assign soft_set = wr_go && (address == OFS_SOFT_REQ) && byteenable[0]
                     && writedata[SOFT_RAISE_BIT];
   assign clr_vec  = (wr_go && (address == OFS_PENDING)) ? (writedata & wmask)
                                                         : 32'h0000_0000;

   // ****************************************
   // pending bits
   // ****************************************

   // level requests re-set the bit each cycle, so firmware must quiet the
   // source before clearing; a set in the clearing cycle wins
   always_ff @(posedge clock) begin
      if (!rstn) begin
         pending_q <= PENDING_RST;
      end else begin
         pending_q <= (pending_q & ~clr_vec) | req_vec;
      end
   end

   // ****************************************
   // mask and steering registers
   // ****************************************

   // mask bit one enables the channel
   always_ff @(posedge clock) begin
      if (!rstn) begin
         mask_q <= MASK_RST;
      end else if (wr_go && (address == OFS_MASK)) begin
         mask_q <= (mask_q & ~wmask) | (writedata & wmask);
      end
   end

   // steer bit one sends the channel to the fast level
   always_ff @(posedge clock) begin
      if (!rstn) begin
         steer_q <= STEER_RST;
      end else if (wr_go && (address == OFS_STEER)) begin
         steer_q <= (steer_q & ~wmask) | (writedata & wmask);
      end
   end

   // ****************************************
   // prioritisation
   // ****************************************
   assign live     = pending_q & mask_q;
   assign fast_src = live & steer_q;
   assign norm_src = live & ~steer_q;
   assign fast_top = top_channel(fast_src);
   assign norm_top = top_channel(norm_src);

   // vectors and levels registered together so software sees a matched pair
   always_ff @(posedge clock) begin
      if (!rstn) begin
         fast_idx_q <= '0;
         fast_vld_q <= 1'b0;
         norm_idx_q <= '0;
         norm_vld_q <= 1'b0;
      end else begin
         fast_idx_q <= fast_top[IDX_W-1:0];
         fast_vld_q <= fast_top[IDX_W];
         norm_idx_q <= norm_top[IDX_W-1:0];
         norm_vld_q <= norm_top[IDX_W];
      end
   end

   // level outputs; the core itself ranks fast above normal
   always_ff @(posedge clock) begin
      if (!rstn) begin
         fast_level_q <= 1'b0;
         norm_level_q <= 1'b0;
         irq_q        <= 1'b0;
      end else begin
         fast_level_q <= |fast_src;
         norm_level_q <= |norm_src;
         irq_q        <= |live;
      end
   end

   // ****************************************
   // avalon slave answer
   // ****************************************

   // fixed one wait cycle: costs a cycle but keeps readdata a flop output
   always_ff @(posedge clock) begin
      if (!rstn) begin
         waitrequest_q <= 1'b1;
      end else if (!waitrequest_q) begin
         waitrequest_q <= 1'b1;
      end else if (read || write) begin
         waitrequest_q <= 1'b0;
      end
   end

   // read data captured as waitrequest drops; unmapped reads return zero
   always_ff @(posedge clock) begin
      if (!rstn) begin
         readdata_q <= 32'h0000_0000;
      end else if (read && waitrequest_q) begin
         readdata_q <= 32'h0000_0000;
         case (address)
            OFS_PENDING:  readdata_q <= pending_q;
            OFS_MASK:     readdata_q <= mask_q;
            OFS_STEER:    readdata_q <= steer_q;
            OFS_FAST_VEC: begin
               readdata_q[IDX_W-1:0]     <= fast_idx_q;
               readdata_q[VEC_VALID_BIT] <= fast_vld_q;
            end
            OFS_NORM_VEC: begin
               readdata_q[IDX_W-1:0]     <= norm_idx_q;
               readdata_q[VEC_VALID_BIT] <= norm_vld_q;
            end
            default:      readdata_q <= 32'h0000_0000;
         endcase
      end
   end

   assign readdata               = readdata_q;
   assign waitrequest            = waitrequest_q;
   assign fast_interrupt_level   = fast_level_q;
   assign normal_interrupt_level = norm_level_q;
   assign irq                    = irq_q;

   // ****************************************
   // checks
   // ****************************************
   chk_pending_latch: assert property (@(posedge clock) disable iff (!rstn)
      (req_vec != 32'h0000_0000) |=> ((pending_q & $past(req_vec)) == $past(req_vec)))
      else $error("request did not latch into pending");

   chk_fast_vector: assert property (@(posedge clock) disable iff (!rstn)
      fast_vld_q |-> (($past(fast_src) >> fast_idx_q) == 32'h0000_0001))
      else $error("fast vector is not the top pending channel");

   chk_norm_vector: assert property (@(posedge clock) disable iff (!rstn)
      norm_vld_q |-> (($past(norm_src) >> norm_idx_q) == 32'h0000_0001))
      else $error("normal vector is not the top pending channel");

   chk_mask_silences: assert property (@(posedge clock) disable iff (!rstn)
      (mask_q == 32'h0000_0000) [*2] |-> !irq_q && !fast_level_q && !norm_level_q)
      else $error("output raised with all channels masked");

   chk_level_steer: assert property (@(posedge clock) disable iff (!rstn)
      (fast_level_q == (|$past(pending_q & mask_q & steer_q)))
      && (norm_level_q == (|$past(pending_q & mask_q & ~steer_q))))
      else $error("level outputs do not follow steering");

   chk_pin_route: assert property (@(posedge clock) disable iff (!rstn)
      $rose(external_pin_request) |-> ##[1:3] pending_q[CH_EXT_PIN])
      else $error("external pin did not reach channel 1");

   chk_soft_raise: assert property (@(posedge clock) disable iff (!rstn)
      soft_set |=> pending_q[CH_SOFTWARE] ##1 (fast_level_q || norm_level_q
      || !$past(mask_q[CH_SOFTWARE])))
      else $error("software raise did not set channel 31");

   chk_timer_order: assert property (@(posedge clock) disable iff (!rstn)
      (small_timer_zero_request || pulse_generator_zero_request) |=>
      (pending_q[CH_SMALL_TMR3+3] || !$past(small_timer_zero_request))
      && (pending_q[CH_PULSE_GEN3+3] || !$past(pulse_generator_zero_request)))
      else $error("unit zero routed to wrong channel");

   chk_bus_answer: assert property (@(posedge clock) disable iff (!rstn)
      (read || write) && waitrequest_q |=> !waitrequest_q ##1 waitrequest_q)
      else $error("bus answer not one wait cycle");

endmodule

// ### include/vip_pkg.sv
// constants shared by the vectored interrupt prioritizer
package vip_pkg;
   // ****************************************
   // channel count and index widths
   // ****************************************
   localparam int NUM_CHANNELS = 32;
   localparam int IDX_W        = 5;
   localparam int ADDR_W       = 5;
   localparam int DATA_W       = 32;

   // ****************************************
   // register byte offsets
   // ****************************************
   localparam logic [ADDR_W-1:0] OFS_PENDING   = 5'h00;
   localparam logic [ADDR_W-1:0] OFS_MASK      = 5'h04;
   localparam logic [ADDR_W-1:0] OFS_STEER     = 5'h08;
   localparam logic [ADDR_W-1:0] OFS_FAST_VEC  = 5'h0C;
   localparam logic [ADDR_W-1:0] OFS_NORM_VEC  = 5'h10;
   localparam logic [ADDR_W-1:0] OFS_SOFT_REQ  = 5'h14;

   // ****************************************
   // field positions and reset values
   // ****************************************
   localparam int VEC_VALID_BIT  = 8;
   localparam int SOFT_RAISE_BIT = 0;
   localparam logic [DATA_W-1:0] PENDING_RST = 32'h0000_0000;
   localparam logic [DATA_W-1:0] MASK_RST    = 32'h0000_0000;
   localparam logic [DATA_W-1:0] STEER_RST   = 32'h0000_0000;

   // ****************************************
   // channel numbers
   // ****************************************
   localparam int CH_BROWNOUT   = 0;
   localparam int CH_EXT_PIN    = 1;
   localparam int CH_WD_EXPIRY  = 2;
   localparam int CH_WD_HALF    = 3;
   localparam int CH_SER_ERR    = 4;
   localparam int CH_SER0_RX    = 5;
   localparam int CH_SER0_TX    = 6;
   localparam int CH_SER1_RX    = 7;
   localparam int CH_SER1_TX    = 8;
   localparam int CH_PMBUS      = 9;
   localparam int CH_DIG_CMP    = 10;
   localparam int CH_FRONT_END0 = 11;
   localparam int CH_SMALL_TMR3 = 14;
   localparam int CH_WIDE_OVF   = 18;
   localparam int CH_WIDE_CAP1  = 19;
   localparam int CH_WIDE_CMP1  = 20;
   localparam int CH_WIDE_CAP0  = 21;
   localparam int CH_WIDE_CMP0  = 22;
   localparam int CH_PWR_MODE   = 23;
   localparam int CH_CONV_DONE  = 24;
   localparam int CH_FAULT_MUX  = 25;
   localparam int CH_PULSE_GEN3 = 26;
   localparam int CH_FAULT_PIN  = 30;
   localparam int CH_SOFTWARE   = 31;
endpackage

// ### test/core_model.sv
// processor core model that takes the fast or the normal interrupt level
`timescale 1ns/1ps
module core_model (
   input  wire logic       clock,
   input  wire logic       rstn,
   input  wire logic       fast_level,
   input  wire logic       normal_level,
   output logic      [1:0] taken_q
);
   // fast wins when both levels are up; normal is only taken while fast is low
   always_ff @(posedge clock) begin
      if (!rstn) begin
         taken_q <= 2'h0;
      end else if (fast_level) begin
         taken_q <= 2'h2;
      end else if (normal_level) begin
         taken_q <= 2'h1;
      end else begin
         taken_q <= 2'h0;
      end
   end
endmodule

// ### test/tb.sv
// self-checking testbench for the vectored interrupt prioritizer
`timescale 1ns/1ps
module tb
   import vip_pkg::*;
;
   logic              clock;
   logic              rstn;
   logic [ADDR_W-1:0] address;
   logic              read;
   logic              write;
   logic [DATA_W-1:0] writedata;
   logic [3:0]        byteenable;
   logic [DATA_W-1:0] readdata;
   logic              waitrequest;
   logic [31:0]       req;
   logic              fast_lvl;
   logic              norm_lvl;
   logic              irq;
   logic [1:0]        taken;
   int                err_total = 0;
   int                tests_run = 0;
   int                cyc = 0;
   logic [31:0]       seed;
   // hand-picked corners: lowest and highest together, lone channel 0, all pending
   logic [31:0]       cp [3] = '{32'h8000_0001, 32'h0000_0001, 32'hffff_ffff};
   logic [31:0]       cm [3] = '{32'hffff_ffff, 32'h0000_0001, 32'h7fff_ffff};
   logic [31:0]       cs [3] = '{32'h0000_0001, 32'h0000_0000, 32'haaaa_aaaa};

   // ****************************************
   // design and core model
   // ****************************************
   vectored_interrupt_prioritizer u_dut (
      .clock(clock), .rstn(rstn), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest),
      .brownout_request(req[0]), .external_pin_request(req[1]),
      .watchdog_expiry_request(req[2]), .watchdog_half_time_request(req[3]),
      .serial_error_request(req[4]), .serial0_receive_request(req[5]),
      .serial0_transmit_request(req[6]), .serial1_receive_request(req[7]),
      .serial1_transmit_request(req[8]), .pmbus_request(req[9]),
      .digital_compare_request(req[10]), .front_end_zero_request(req[11]),
      .front_end_one_request(req[12]), .front_end_two_request(req[13]),
      .small_timer_three_request(req[14]), .small_timer_two_request(req[15]),
      .small_timer_one_request(req[16]), .small_timer_zero_request(req[17]),
      .wide_timer_overflow_request(req[18]), .wide_timer_capture1_request(req[19]),
      .wide_timer_compare1_request(req[20]), .wide_timer_capture0_request(req[21]),
      .wide_timer_compare0_request(req[22]), .power_current_mode_request(req[23]),
      .conversion_done_request(req[24]), .fault_mux_request(req[25]),
      .pulse_generator_three_request(req[26]), .pulse_generator_two_request(req[27]),
      .pulse_generator_one_request(req[28]), .pulse_generator_zero_request(req[29]),
      .fault_pin_request(req[30]), .fast_interrupt_level(fast_lvl),
      .normal_interrupt_level(norm_lvl), .irq(irq));

   core_model u_core (.clock(clock), .rstn(rstn), .fast_level(fast_lvl),
                      .normal_level(norm_lvl), .taken_q(taken));

   // ****************************************
   // helpers
   // ****************************************
   function automatic logic [31:0] xs(input logic [31:0] x);
      logic [31:0] y;
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      return y ^ (y << 5);
   endfunction

   // vector word: valid in bit 8, top set channel in the low bits, zero when none
   function automatic logic [31:0] vec_of(input logic [31:0] x);
      vec_of = 32'h0000_0000;
      for (int i = 0; i < NUM_CHANNELS; i++) begin
         if (x[i]) begin
            vec_of = 32'h0000_0100 | 32'(i);
         end
      end
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // one avalon access; request held until waitrequest is sampled low
   // no local limit: only the bench timeout may end a stuck wait
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                      input logic [3:0] be, output logic [31:0] q);
      @(posedge clock);
      read <= !wr;
      write <= wr;
      address <= a;
      writedata <= d;
      byteenable <= be;
      do begin
         @(posedge clock);
      end while (waitrequest !== 1'b0);
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask

   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, 4'hf, q);
   endtask

   task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0000_0000, 4'hf, q);
      check(q, exp);
   endtask

   // one-cycle request burst, then time for the pin synchronisers and levels
   task automatic pulse(input logic [31:0] v);
      @(posedge clock);
      req <= v;
      @(posedge clock);
      req <= 32'h0000_0000;
      repeat (6) @(posedge clock);
   endtask

   task automatic close_out;
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // ****************************************
   // clock, timeout, main sequence
   // ****************************************
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   // a hung handshake must not stall the run forever
   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         close_out;
      end
   end

   initial begin
      logic [31:0] p, m, s, q;
      rstn = 1'b0;
      read = 1'b0;
      write = 1'b0;
      address = 5'h00;
      writedata = 32'h0000_0000;
      byteenable = 4'hf;
      req = 32'h0000_0000;
      seed = 32'h0000_ed3c;
      repeat (12) @(posedge clock);
      rstn <= 1'b1;
      repeat (2) @(posedge clock);
      rd_chk(OFS_PENDING, PENDING_RST);
      rd_chk(OFS_MASK, MASK_RST);
      rd_chk(OFS_STEER, STEER_RST);
      rd_chk(OFS_FAST_VEC, 32'h0000_0000);
      rd_chk(OFS_NORM_VEC, 32'h0000_0000);
      rd_chk(5'h18, 32'h0000_0000);
      // every source lands on its own channel; all masked so no level rises
      for (int ch = 0; ch < 31; ch++) begin
         pulse(32'h0000_0001 << ch);
         rd_chk(OFS_PENDING, 32'h0000_0001 << ch);
         check({29'h0, fast_lvl, norm_lvl, irq}, 32'h0000_0000);
         wr(OFS_PENDING, 32'h0000_0001 << ch);
         rd_chk(OFS_PENDING, 32'h0000_0000);
      end
      wr(OFS_SOFT_REQ, 32'h0000_0001);
      rd_chk(OFS_PENDING, 32'h8000_0000);
      rd_chk(OFS_SOFT_REQ, 32'h0000_0000);
      wr(OFS_PENDING, 32'hffff_ffff);
      // partial lane write touches only its byte
      bus(1'b1, OFS_MASK, 32'hffff_ffff, 4'b0010, q);
      rd_chk(OFS_MASK, 32'h0000_ff00);
      // software raise ignored without lane zero
      bus(1'b1, OFS_SOFT_REQ, 32'h0000_0001, 4'b1110, q);
      rd_chk(OFS_PENDING, 32'h0000_0000);
      // pending clear limited to its enabled lanes
      wr(OFS_SOFT_REQ, 32'h0000_0001);
      bus(1'b1, OFS_PENDING, 32'hffff_ffff, 4'b0111, q);
      rd_chk(OFS_PENDING, 32'h8000_0000);
      wr(OFS_PENDING, 32'hffff_ffff);
      // a clear lost against a still-high source
      @(posedge clock);
      req <= 32'h0000_0020;
      wr(OFS_PENDING, 32'h0000_0020);
      rd_chk(OFS_PENDING, 32'h0000_0020);
      req <= 32'h0000_0000;
      wr(OFS_PENDING, 32'hffff_ffff);
      // corners first, then random pending, mask and steering
      for (int i = 0; i < 33; i++) begin
         if (i < 3) begin
            p = cp[i];
            m = cm[i];
            s = cs[i];
         end else begin
            seed = xs(seed);
            p = seed;
            seed = xs(seed);
            m = seed;
            seed = xs(seed);
            s = seed;
         end
         wr(OFS_MASK, m);
         wr(OFS_STEER, s);
         if (p[31]) begin
            wr(OFS_SOFT_REQ, 32'h0000_0001);
         end
         pulse({1'b0, p[30:0]});
         rd_chk(OFS_FAST_VEC, vec_of(p & m & s));
         rd_chk(OFS_NORM_VEC, vec_of(p & m & ~s));
         check({29'h0, fast_lvl, norm_lvl, irq},
               {29'h0, |(p & m & s), |(p & m & ~s), |(p & m)});
         check({30'h0, taken}, (|(p & m & s)) ? 32'h2 : (|(p & m & ~s)) ? 32'h1 : 32'h0);
         wr(OFS_PENDING, 32'hffff_ffff);
      end
      repeat (3) @(posedge clock);
      check({31'h0, irq}, 32'h0000_0000);
      close_out;
   end
endmodule
